// >>> swb_alu_regs.vh
// Register map, field layout and codes of the subtract-with-borrow datapath
`ifndef SWB_ALU_REGS_VH
`define SWB_ALU_REGS_VH

// Register byte offsets
`define SWB_OFF_CTRL        8'h00
`define SWB_OFF_FIRST       8'h04
`define SWB_OFF_SECOND      8'h08
`define SWB_OFF_SHAMT       8'h0C
`define SWB_OFF_OPER        8'h10
`define SWB_OFF_IMM         8'h14
`define SWB_OFF_FLAGS       8'h18
`define SWB_OFF_RESULT      8'h1C
`define SWB_OFF_STATUS      8'h20

// Control register fields
`define SWB_CTRL_GO         0
`define SWB_CTRL_PLAIN      1

// Operation register fields
`define SWB_OPER_IMM_SEL    0
`define SWB_OPER_KIND_LO    1
`define SWB_OPER_KIND_HI    3
`define SWB_OPER_FROM_REG   4
`define SWB_OPER_AMT_LO     5
`define SWB_OPER_AMT_HI     9
`define SWB_OPER_COND_LO    12
`define SWB_OPER_COND_HI    15
`define SWB_OPER_SETF       16
`define SWB_OPER_MASK       32'h0001_F3FF

// Immediate register fields
`define SWB_IMM_PAT_LO      0
`define SWB_IMM_PAT_HI      7
`define SWB_IMM_ROT_LO      8
`define SWB_IMM_ROT_HI      12
`define SWB_IMM_MASK        32'h0000_1FFF

// Flag bit positions
`define SWB_FLAG_V          0
`define SWB_FLAG_C          1
`define SWB_FLAG_Z          2
`define SWB_FLAG_N          3

// Status bit positions
`define SWB_STAT_DONE       0
`define SWB_STAT_SKIP       1

// Reset values
`define SWB_RST_OPER        32'h0000_E000
`define SWB_RST_FLAGS       4'h0

// Shift kinds
`define SWB_SH_LSL          3'h0
`define SWB_SH_LSR          3'h1
`define SWB_SH_ASR          3'h2
`define SWB_SH_ROR          3'h3
`define SWB_SH_RRX          3'h4

// Condition codes
`define SWB_CC_EQ           4'h0
`define SWB_CC_NE           4'h1
`define SWB_CC_CS           4'h2
`define SWB_CC_CC           4'h3
`define SWB_CC_MI           4'h4
`define SWB_CC_PL           4'h5
`define SWB_CC_VS           4'h6
`define SWB_CC_VC           4'h7
`define SWB_CC_HI           4'h8
`define SWB_CC_LS           4'h9
`define SWB_CC_GE           4'hA
`define SWB_CC_LT           4'hB
`define SWB_CC_GT           4'hC
`define SWB_CC_LE           4'hD
`define SWB_CC_AL           4'hE
`define SWB_CC_NV           4'hF

`endif

// >>> swb_shift.v
// Barrel shifter used for register operands and immediate rotation
`timescale 1ns/100ps
module swb_shift (
   input  wire [31:0] value,
   input  wire [2:0]  kind,
   input  wire [7:0]  amount,
   input  wire        carry_in,
   output reg  [31:0] shifted
);
`include "swb_alu_regs.vh"

   reg [63:0] twice;
   reg [31:0] arith;

   always @* begin
      twice = {value, value} >> amount[4:0];
      // Kept apart: an unsigned ternary arm would turn >>> into a logical shift
      arith = $signed(value) >>> amount[4:0];
      case (kind)
         `SWB_SH_LSL: begin
            // Amounts of 32 and more clear the word
            shifted = (amount > 8'h1F) ? 32'h0000_0000
                                       : (value << amount[4:0]);
         end
         `SWB_SH_LSR: begin
            shifted = (amount > 8'h1F) ? 32'h0000_0000
                                       : (value >> amount[4:0]);
         end
         `SWB_SH_ASR: begin
            shifted = (amount > 8'h1F) ? {32{value[31]}} : arith;
         end
         `SWB_SH_ROR: begin
            // Rotation wraps, so only the low five bits matter
            shifted = twice[31:0];
         end
         `SWB_SH_RRX: begin
            shifted = {carry_in, value[31:1]};
         end
         default: begin
            shifted = value;
         end
      endcase
   end

endmodule

// >>> swb_alu.v
// Subtract-with-borrow datapath with its AHB-Lite register slave
// Operation
// - Result is first source minus flexible operand, minus one, plus carry.
// - Both operands and the difference are 32-bit words.
// - Immediate operand is any 8-bit pattern rotated within the word.
// - Carry of a plain low-word subtract feeds the next borrow subtract.
// - N, Z, C, V change only when flag update is requested.
// - Failing condition leaves result and flags untouched.
// - Register operand shifter does LSL, LSR, ASR, ROR and RRX.
`timescale 1ns/100ps
module swb_alu (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg         hreadyout,
   output reg         hresp,
   output reg  [31:0] hrdata
);
`include "swb_alu_regs.vh"

   // Software visible state
   reg  [31:0] first_source_register;
   reg  [31:0] second_value;
   reg  [31:0] shift_amount_register;
   reg  [31:0] oper;
   reg  [31:0] imm;
   reg  [3:0]  flags;
   reg  [31:0] result;
   reg  [1:0]  status;

   // Bus data phase tracking
   reg         wr_pend;
   reg         rd_pend;
   reg  [7:0]  addr_q;

   // Datapath nets
   wire [31:0] reg_operand;
   wire [31:0] imm_operand;
   wire [31:0] flexible_operand;
   wire [7:0]  shift_amt;
   wire        carry_in;
   wire [32:0] sum;
   wire [31:0] diff;
   wire        new_n;
   wire        new_z;
   wire        new_c;
   wire        new_v;

   // Condition decode
   reg         cond_pass;
   wire [3:0]  cond;
   wire        fn;
   wire        fz;
   wire        fc;
   wire        fv;
   wire        go;
   reg  [31:0] next_rdata;
   reg  [31:0] next_result;
   reg  [3:0]  next_flags;
   reg  [1:0]  next_status;
   wire        ctrl_wr;
   wire        accept;

   // IDLE and BUSY carry no transfer, so only htrans[1] matters
   assign accept = hsel & hready & htrans[1];

   // Register operand: amount from the register or the immediate field
   // Only the low byte of the shift amount register counts
   assign shift_amt = oper[`SWB_OPER_FROM_REG] ? shift_amount_register[7:0]
                    : {3'h0, oper[`SWB_OPER_AMT_HI:`SWB_OPER_AMT_LO]};

   swb_shift u_reg_shift (
      .value    (second_value),
      .kind     (oper[`SWB_OPER_KIND_HI:`SWB_OPER_KIND_LO]),
      .amount   (shift_amt),
      .carry_in (flags[`SWB_FLAG_C]),
      .shifted  (reg_operand)
   );

   // Immediate: 8-bit pattern rotated right by any amount
   swb_shift u_imm_rot (
      .value    ({24'h00_0000, imm[`SWB_IMM_PAT_HI:`SWB_IMM_PAT_LO]}),
      .kind     (`SWB_SH_ROR),
      .amount   ({3'h0, imm[`SWB_IMM_ROT_HI:`SWB_IMM_ROT_LO]}),
      .carry_in (1'b0),
      .shifted  (imm_operand)
   );

   assign flexible_operand = oper[`SWB_OPER_IMM_SEL] ? imm_operand
                                                     : reg_operand;

   // Plain subtract forces carry in, so the low word starts the chain
   assign carry_in = hwdata[`SWB_CTRL_PLAIN] ? 1'b1
                                             : flags[`SWB_FLAG_C];

   // Subtraction as addition of the complement plus carry
   assign sum  = {1'b0, first_source_register} + {1'b0, ~flexible_operand}
               + {32'h0000_0000, carry_in};
   assign diff = sum[31:0];

   assign new_n = diff[31];
   assign new_z = (diff == 32'h0000_0000);
   // Carry out set means no borrow was taken
   assign new_c = sum[32];
   // Overflow: operands differ in sign and the result left the minuend's
   assign new_v = (first_source_register[31] ^ flexible_operand[31])
                & (first_source_register[31] ^ diff[31]);

   // Condition check on the flags held before the instruction
   assign cond = oper[`SWB_OPER_COND_HI:`SWB_OPER_COND_LO];
   assign fn   = flags[`SWB_FLAG_N];
   assign fz   = flags[`SWB_FLAG_Z];
   assign fc   = flags[`SWB_FLAG_C];
   assign fv   = flags[`SWB_FLAG_V];

   always @* begin
      case (cond)
         `SWB_CC_EQ: begin
            cond_pass = fz;
         end
         `SWB_CC_NE: begin
            cond_pass = ~fz;
         end
         `SWB_CC_CS: begin
            cond_pass = fc;
         end
         `SWB_CC_CC: begin
            cond_pass = ~fc;
         end
         `SWB_CC_MI: begin
            cond_pass = fn;
         end
         `SWB_CC_PL: begin
            cond_pass = ~fn;
         end
         `SWB_CC_VS: begin
            cond_pass = fv;
         end
         `SWB_CC_VC: begin
            cond_pass = ~fv;
         end
         `SWB_CC_HI: begin
            cond_pass = fc & ~fz;
         end
         `SWB_CC_LS: begin
            cond_pass = ~fc | fz;
         end
         `SWB_CC_GE: begin
            cond_pass = (fn == fv);
         end
         `SWB_CC_LT: begin
            cond_pass = (fn != fv);
         end
         `SWB_CC_GT: begin
            cond_pass = ~fz & (fn == fv);
         end
         `SWB_CC_LE: begin
            cond_pass = fz | (fn != fv);
         end
         `SWB_CC_AL: begin
            cond_pass = 1'b1;
         end
         default: begin
            cond_pass = 1'b0;
         end
      endcase
   end

   // Launch happens at the end of the control write data phase
   // Control has no storage: its bits act only in that data phase
   assign ctrl_wr = wr_pend & (addr_q == `SWB_OFF_CTRL);
   assign go      = ctrl_wr & hwdata[`SWB_CTRL_GO];

   // Read mux
   // Unmapped offsets and the write-only control word read as zero
   always @* begin
      case (addr_q)
         `SWB_OFF_FIRST: begin
            next_rdata = first_source_register;
         end
         `SWB_OFF_SECOND: begin
            next_rdata = second_value;
         end
         `SWB_OFF_SHAMT: begin
            next_rdata = shift_amount_register;
         end
         `SWB_OFF_OPER: begin
            next_rdata = oper;
         end
         `SWB_OFF_IMM: begin
            next_rdata = imm;
         end
         `SWB_OFF_FLAGS: begin
            next_rdata = {28'h000_0000, flags};
         end
         `SWB_OFF_RESULT: begin
            next_rdata = result;
         end
         `SWB_OFF_STATUS: begin
            next_rdata = {30'h0000_0000, status};
         end
         default: begin
            next_rdata = 32'h0000_0000;
         end
      endcase
   end

   // Bus phase tracking; reads take one wait state so data is a flop
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend   <= 1'b0;
         rd_pend   <= 1'b0;
         addr_q    <= 8'h00;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0000_0000;
      end else begin
         // Every offset is legal, so the response stays OKAY
         hresp <= 1'b0;
         if (rd_pend) begin
            hrdata    <= next_rdata;
            hreadyout <= 1'b1;
            rd_pend   <= 1'b0;
         end else if (hready) begin
            wr_pend <= accept & hwrite;
            if (accept) begin
               addr_q <= haddr[7:0];
            end
            if (accept & ~hwrite) begin
               rd_pend   <= 1'b1;
               hreadyout <= 1'b0;
            end
         end
      end
   end

   // Launch outcome; a skipped launch only updates the status word
   always @* begin
      next_result = result;
      next_flags  = flags;
      next_status = status;
      if (go) begin
         next_status = {~cond_pass, cond_pass};
         if (cond_pass) begin
            next_result = diff;
            if (oper[`SWB_OPER_SETF]) begin
               next_flags = {new_n, new_z, new_c, new_v};
            end
         end
      end
   end

   // Register writes and execution
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         first_source_register <= 32'h0000_0000;
         second_value          <= 32'h0000_0000;
         shift_amount_register <= 32'h0000_0000;
         oper                  <= `SWB_RST_OPER;
         imm                   <= 32'h0000_0000;
         flags                 <= `SWB_RST_FLAGS;
         result                <= 32'h0000_0000;
         status                <= 2'h0;
      end else begin
         result <= next_result;
         flags  <= next_flags;
         status <= next_status;
         // A bus write to the flags comes last so that it wins
         if (wr_pend) begin
            case (addr_q)
               `SWB_OFF_FIRST: begin
                  first_source_register <= hwdata;
               end
               `SWB_OFF_SECOND: begin
                  second_value <= hwdata;
               end
               `SWB_OFF_SHAMT: begin
                  shift_amount_register <= hwdata;
               end
               `SWB_OFF_OPER: begin
                  oper <= hwdata & `SWB_OPER_MASK;
               end
               `SWB_OFF_IMM: begin
                  imm <= hwdata & `SWB_IMM_MASK;
               end
               `SWB_OFF_FLAGS: begin
                  flags <= hwdata[3:0];
               end
               default: begin
               end
            endcase
         end
      end
   end

endmodule

// >>> swb_alu_chk.sv
// Bus protocol checker for the subtract-with-borrow register slave
`timescale 1ns/100ps
module swb_alu_chk (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata
);
   wire tk = hsel & hready & htrans[1];
   wire rd = tk & ~hwrite;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_okay; hresp == 1'b0; endproperty
   a_okay: assert property (p_okay) else $error("error response");
   property p_rd_wait; rd |=> !hreadyout ##1 hreadyout; endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
   property p_wr_fast; tk && hwrite |=> hreadyout; endproperty
   a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
   property p_low_one; !hreadyout |=> hreadyout; endproperty
   a_low_one: assert property (p_low_one) else $error("long stall");
   // Read data may only move when a read is being answered
   property p_hold; !$stable(hrdata) |-> $past(!hreadyout); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_ctrl0; rd && haddr[7:0] == 8'h00 |=> ##1 hrdata == 32'h0;
   endproperty
   a_ctrl0: assert property (p_ctrl0) else $error("control not zero");
   property p_flres; rd && haddr[7:0] == 8'h18 |=> ##1 hrdata[31:4] == 28'h0;
   endproperty
   a_flres: assert property (p_flres) else $error("flag spare bits");
   property p_unmap; rd && haddr[7:0] > 8'h20 |=> ##1 hrdata == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped not zero");
   property p_stat; rd && haddr[7:0] == 8'h20 |=>
      ##1 hrdata[31:2] == 30'h0 && hrdata[1:0] != 2'h3; endproperty
   a_stat: assert property (p_stat) else $error("status bits wrong");
   c_go: cover property (tk && hwrite && haddr[7:0] == 8'h00);
   c_res: cover property (rd && haddr[7:0] == 8'h1C);
   c_stat: cover property (rd && haddr[7:0] == 8'h20);
endmodule

bind swb_alu swb_alu_chk chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
   .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .hrdata(hrdata));

// >>> tb_top.sv
// Self-checking bench for the subtract-with-borrow register slave
`timescale 1ns/100ps
`include "swb_alu_regs.vh"
module tb_top;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   int          n_mismatch, compares, cyc;
   swb_alu uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata));
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task results;
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Entered just after a rising edge; hready is judged at rising edges
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
      chk("hresp", {31'h0, hresp}, 32'h0);
   endtask
   task run(input logic [31:0] a, input logic [31:0] b, input logic [19:0] op,
      input logic [15:0] im, input logic [4:0] fl, input logic [1:0] ct,
      input logic [31:0] r, input logic [3:0] f, input logic sk);
      xfer(1'b1, `SWB_OFF_FIRST, a);
      xfer(1'b1, `SWB_OFF_SECOND, b);
      xfer(1'b1, `SWB_OFF_OPER, {12'h0, op});
      xfer(1'b1, `SWB_OFF_IMM, {16'h0, im});
      // fl[4] set keeps the flags left by the previous operation
      if (!fl[4]) xfer(1'b1, `SWB_OFF_FLAGS, {28'h0, fl[3:0]});
      xfer(1'b1, `SWB_OFF_CTRL, {30'h0, ct});
      xfer(1'b0, `SWB_OFF_RESULT, 32'h0);
      chk("result", q, r);
      xfer(1'b0, `SWB_OFF_FLAGS, 32'h0);
      chk("flags", q, {28'h0, f});
      xfer(1'b0, `SWB_OFF_STATUS, 32'h0);
      chk("status", q, {30'h0, sk, ~sk});
      $display("operation test done");
   endtask
   // Every condition code against one flag setting; pm bit n passes code n
   task conds(input logic [3:0] fl, input logic [15:0] pm);
      int c;
      xfer(1'b1, `SWB_OFF_FLAGS, {28'h0, fl});
      for (c = 0; c < 16; c++) begin
         xfer(1'b1, `SWB_OFF_OPER, {16'h0, c[3:0], 12'h0});
         xfer(1'b1, `SWB_OFF_CTRL, 32'h1);
         xfer(1'b0, `SWB_OFF_STATUS, 32'h0);
         chk("cond status", q, {30'h0, ~pm[c], pm[c]});
      end
      xfer(1'b0, `SWB_OFF_FLAGS, 32'h0);
      chk("cond flags", q, {28'h0, fl});
      $display("condition test done");
   endtask
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         results;
      end
   end
   initial begin
      hresetn = 1'b0; hsel = 1'b0; htrans = 2'h0; haddr = 32'h0;
      hwrite = 1'b0; hwdata = 32'h0; hsize = 3'h2;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      xfer(1'b0, `SWB_OFF_OPER, 32'h0);
      chk("oper reset", q, `SWB_RST_OPER);
      xfer(1'b0, `SWB_OFF_FLAGS, 32'h0);
      chk("flags reset", q, 32'h0);
      xfer(1'b1, 8'h40, 32'hFFFFFFFF);
      xfer(1'b0, 8'h40, 32'h0);
      chk("unmapped", q, 32'h0);
      xfer(1'b1, `SWB_OFF_RESULT, 32'hFFFFFFFF);
      xfer(1'b0, `SWB_OFF_RESULT, 32'h0);
      chk("result ro", q, 32'h0);
      xfer(1'b0, `SWB_OFF_CTRL, 32'h0);
      chk("ctrl reads zero", q, 32'h0);
      xfer(1'b1, `SWB_OFF_SHAMT, 32'h8);
      $display("register test done");
      run(32'h0, 32'h1, 20'h1E000, 16'h0, 5'h00, 2'h3,
         32'hFFFFFFFF, 4'h8, 1'h0);
      run(32'h1, 32'h0, 20'h1E000, 16'h0, 5'h10, 2'h1,
         32'h0, 4'h6, 1'h0);
      run(32'h7F000000, 32'h0, 20'h1E001, 16'h08FF, 5'h02, 2'h1,
         32'h80000000, 4'h9, 1'h0);
      run(32'h80000001, 32'h0, 20'h1E001, 16'h0103, 5'h02, 2'h1,
         32'h0, 4'h6, 1'h0);
      run(32'h100, 32'h10, 20'h0E080, 16'h0, 5'h02, 2'h1,
         32'h0, 4'h2, 1'h0);
      run(32'h08000000, 32'h80000000, 20'h0E082, 16'h0, 5'h02, 2'h1,
         32'h0, 4'h2, 1'h0);
      run(32'hF8000000, 32'h80000000, 20'h0E084, 16'h0, 5'h02, 2'h1,
         32'h0, 4'h2, 1'h0);
      run(32'hF0000000, 32'hF, 20'h0E086, 16'h0, 5'h02, 2'h1,
         32'h0, 4'h2, 1'h0);
      run(32'h100, 32'h1, 20'h0E010, 16'h0, 5'h00, 2'h1,
         32'hFFFFFFFF, 4'h0, 1'h0);
      run(32'h80000001, 32'h2, 20'h0E008, 16'h0, 5'h02, 2'h1,
         32'h0, 4'h2, 1'h0);
      run(32'h5, 32'h0, 20'h10000, 16'h0, 5'h00, 2'h1,
         32'h0, 4'h0, 1'h1);
      run(32'h5, 32'h0, 20'h1F000, 16'h0, 5'h04, 2'h1,
         32'h0, 4'h4, 1'h1);
      run(32'h5, 32'h0, 20'h10000, 16'h0, 5'h04, 2'h1,
         32'h4, 4'h2, 1'h0);
      conds(4'h0, 16'h56AA);
      conds(4'hE, 16'h6A95);
      conds(4'hB, 16'h5556);
      results;
   end
endmodule
